// File: hdl/lfom_fgen_sel.sv
// Picks the step or ramp parameters that reach the function generator.
// Assumes source and type codes already checked by the object map.
`timescale 1ns/1ps
module lfom_fgen_sel (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // Selection
    input  wire logic [15:0] src,
    input  wire logic [15:0] ftype,
    // Stored parameters
    input  wire logic [31:0] step_lo,
    input  wire logic [31:0] step_hi,
    input  wire logic [31:0] ramp_lo,
    input  wire logic [31:0] ramp_hi,
    input  wire logic [31:0] rise_ms,
    input  wire logic [31:0] fall_ms,
    // Applied parameters
    output logic             step_on,
    output logic             ramp_on,
    output logic      [31:0] level_lo,
    output logic      [31:0] level_hi,
    output logic      [31:0] rise_out,
    output logic      [31:0] fall_out
);
    logic fgen_sel;
    logic step_sel;
    logic ramp_sel;

    assign fgen_sel = (src == lfom_pkg::SRC_FGEN);
    assign step_sel = fgen_sel && (ftype == lfom_pkg::FT_STEP);
    assign ramp_sel = fgen_sel && (ftype == lfom_pkg::FT_RAMP);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            step_on  <= 1'b0;
            ramp_on  <= 1'b0;
            level_lo <= lfom_pkg::FPARAM_RST;
            level_hi <= lfom_pkg::FPARAM_RST;
            rise_out <= lfom_pkg::FPARAM_RST;
            fall_out <= lfom_pkg::FPARAM_RST;
        end else begin
            step_on  <= step_sel;
            ramp_on  <= ramp_sel;
            level_lo <= ramp_sel ? ramp_lo : (step_sel ? step_lo : lfom_pkg::FPARAM_RST);
            level_hi <= ramp_sel ? ramp_hi : (step_sel ? step_hi : lfom_pkg::FPARAM_RST);
            rise_out <= ramp_sel ? rise_ms : lfom_pkg::FPARAM_RST;
            fall_out <= ramp_sel ? fall_ms : lfom_pkg::FPARAM_RST;
        end
    end

endmodule

// File: hdl/lfom_object_map.sv
// Object map and slave state gating of a programmable DC load.
// Assumes a fieldbus front end that presents Set/Get and process data per cycle.
`timescale 1ns/1ps
module lfom_object_map (
    // Clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     srst,
    // State commands from master
    input  wire logic                     esm_req_valid,
    input  wire lfom_pkg::lfom_esm_e      esm_req_state,
    output lfom_pkg::lfom_esm_e           esm_state,
    output logic                          esm_refused,
    // Service data requests
    input  wire logic                     sdo_valid,
    input  wire logic                     sdo_write,
    input  wire logic [3:0]               sdo_proto,
    input  wire logic [15:0]              sdo_instance,
    input  wire logic [31:0]              sdo_wdata,
    output logic                          sdo_rsp_valid,
    output logic                          sdo_rsp_ok,
    output logic      [31:0]              sdo_rdata,
    // Process data
    input  wire logic                     rxpdo_valid,
    input  wire logic [31:0]              rxpdo_setpoint,
    input  wire logic                     txpdo_tick,
    output logic                          txpdo_valid,
    output logic      [31:0]              txpdo_volt,
    // Set-point inputs and output
    input  wire logic                     panel_sp_valid,
    input  wire logic [31:0]              panel_setpoint,
    input  wire logic [31:0]              fgen_wave,
    input  wire logic [31:0]              analog_setpoint,
    output logic      [31:0]              setpoint_out,
    // Function generator parameters
    output logic                          fgen_step_on,
    output logic                          fgen_ramp_on,
    output logic      [31:0]              fgen_level_lo,
    output logic      [31:0]              fgen_level_hi,
    output logic      [31:0]              fgen_rise_ms,
    output logic      [31:0]              fgen_fall_ms,
    // Front panel
    input  wire logic [7:0]               panel_btn,
    output logic      [7:0]               panel_btn_gated,
    output logic                          panel_locked,
    // Voltage sensing
    input  wire logic [31:0]              meas_volt_local,
    input  wire logic [31:0]              meas_volt_remote,
    output logic      [31:0]              calc_volt,
    output logic                          sense_remote,
    // Defaults reload
    output logic                          restore_pulse,
    output logic                          restore_hard
);
    lfom_pkg::lfom_esm_e esm_q;
    logic [31:0] fparam_q [lfom_pkg::FP_NUM];
    logic [15:0] ftype_q;
    logic [15:0] sense_q;
    logic [15:0] src_q;
    logic        lock_q;
    logic [31:0] local_sp_q;
    logic        proto_ok;
    logic        sdo_acc;
    logic [15:0] foff;
    logic        f_wr;
    logic        f_rd;
    logic [2:0]  f_idx;
    logic        wr_ok;
    logic        rd_ok;
    logic [31:0] rd_val;
    logic        wr_go;
    logic        restore_now;
    logic        esm_legal;

    // Write strobe for one instance
    function automatic logic wr_hit(input logic [15:0] inst);
        return wr_go && (sdo_instance == inst);
    endfunction

    // Service access gating
    assign proto_ok = (sdo_proto == lfom_pkg::PROTO_BASIC) ||
                      (sdo_proto == lfom_pkg::PROTO_EOE);
    assign sdo_acc  = sdo_valid && proto_ok && (esm_q != lfom_pkg::ESM_INIT);
    assign foff     = sdo_instance - lfom_pkg::INST_FPARAM_BASE;
    assign f_wr     = (foff < lfom_pkg::FPARAM_SPAN) && !foff[0];
    assign f_rd     = (foff < lfom_pkg::FPARAM_SPAN) && foff[0];
    assign f_idx    = foff[3:1];

    // Write decode and value checks
    always_comb begin
        wr_ok = f_wr;
        unique case (sdo_instance)
            lfom_pkg::INST_FTYPE_WR:  wr_ok = sdo_wdata[15:0] <= lfom_pkg::FT_RAMP;
            lfom_pkg::INST_LOCK_WR:   wr_ok = 1'b1;
            lfom_pkg::INST_SENSE_WR:  wr_ok = sdo_wdata[15:0] <= lfom_pkg::SENSE_REMOTE;
            lfom_pkg::INST_SRC_WR:    wr_ok = (sdo_wdata[15:0] == lfom_pkg::SRC_PANEL) ||
                                              (sdo_wdata[15:0] == lfom_pkg::SRC_FGEN) ||
                                              (sdo_wdata[15:0] == lfom_pkg::SRC_ANALOG);
            lfom_pkg::INST_RELOAD_WR: wr_ok = sdo_wdata[15:0] <= lfom_pkg::RESTORE_HARD;
            default:                  wr_ok = f_wr;
        endcase
    end

    // Read decode
    always_comb begin
        rd_ok  = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (sdo_instance)
            lfom_pkg::INST_FTYPE_RD: rd_val = {16'h0000, ftype_q};
            lfom_pkg::INST_LOCK_RD:  rd_val = {31'h0000_0000, lock_q};
            lfom_pkg::INST_SENSE_RD: rd_val = {16'h0000, sense_q};
            lfom_pkg::INST_SRC_RD:   rd_val = {16'h0000, src_q};
            default: begin
                rd_ok  = f_rd;
                rd_val = f_rd ? fparam_q[f_idx] : 32'h0000_0000;
            end
        endcase
    end

    assign wr_go       = sdo_acc && sdo_write && wr_ok;
    assign restore_now = wr_go && (sdo_instance == lfom_pkg::INST_RELOAD_WR);

    // Service response, one cycle after the request
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sdo_rsp_valid <= 1'b0;
            sdo_rsp_ok    <= 1'b0;
            sdo_rdata     <= 32'h0000_0000;
        end else begin
            sdo_rsp_valid <= sdo_valid;
            sdo_rsp_ok    <= sdo_acc && (sdo_write ? wr_ok : rd_ok);
            sdo_rdata     <= (sdo_acc && !sdo_write && rd_ok) ? rd_val : 32'h0000_0000;
        end
    end

    // Float parameters, stored whatever the source
    always_ff @(posedge core_clk) begin
        if (srst || (restore_now && sdo_wdata[15:0] == lfom_pkg::RESTORE_HARD)) begin
            for (int i = 0; i < lfom_pkg::FP_NUM; i++) begin
                fparam_q[i] <= lfom_pkg::FPARAM_RST;
            end
        end else if (wr_go && f_wr) begin
            fparam_q[f_idx] <= sdo_wdata;
        end
    end

    // Configuration objects
    always_ff @(posedge core_clk) begin
        if (srst || restore_now) begin
            ftype_q <= lfom_pkg::FTYPE_RST;
            lock_q  <= lfom_pkg::LOCK_RST;
            sense_q <= lfom_pkg::SENSE_RST;
            src_q   <= lfom_pkg::SRC_RST;
        end else begin
            if (wr_hit(lfom_pkg::INST_FTYPE_WR)) begin
                ftype_q <= sdo_wdata[15:0];
            end
            if (wr_hit(lfom_pkg::INST_LOCK_WR)) begin
                lock_q <= sdo_wdata[0];
            end
            if (wr_hit(lfom_pkg::INST_SENSE_WR)) begin
                sense_q <= sdo_wdata[15:0];
            end
            if (wr_hit(lfom_pkg::INST_SRC_WR)) begin
                src_q <= sdo_wdata[15:0];
            end
        end
    end

    // Restore indication
    always_ff @(posedge core_clk) begin
        if (srst) begin
            restore_pulse <= 1'b0;
            restore_hard  <= 1'b0;
        end else begin
            restore_pulse <= restore_now;
            restore_hard  <= restore_now && (sdo_wdata[15:0] == lfom_pkg::RESTORE_HARD);
        end
    end

    // Slave state machine: up one step, or down to any lower state
    assign esm_legal = (esm_req_state <= esm_q) ||
                       ({1'b0, esm_req_state} == {1'b0, esm_q} + 3'h1);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            esm_q       <= lfom_pkg::ESM_INIT;
            esm_refused <= 1'b0;
        end else begin
            esm_refused <= esm_req_valid && !esm_legal;
            if (esm_req_valid && esm_legal) begin
                esm_q <= esm_req_state;
            end
        end
    end

    assign esm_state = esm_q;

    // Local set point from cyclic data or panel
    always_ff @(posedge core_clk) begin
        if (srst) begin
            local_sp_q <= lfom_pkg::SETPOINT_RST;
        end else if (rxpdo_valid && esm_q == lfom_pkg::ESM_OP) begin
            local_sp_q <= rxpdo_setpoint;
        end else if (panel_sp_valid) begin
            local_sp_q <= panel_setpoint;
        end
    end

    // Set-point routing
    always_ff @(posedge core_clk) begin
        if (srst) begin
            setpoint_out <= lfom_pkg::SETPOINT_RST;
        end else begin
            unique case (src_q)
                lfom_pkg::SRC_PANEL:  setpoint_out <= local_sp_q;
                lfom_pkg::SRC_FGEN:   setpoint_out <= fgen_wave;
                lfom_pkg::SRC_ANALOG: setpoint_out <= analog_setpoint;
                default:              setpoint_out <= setpoint_out;
            endcase
        end
    end

    // Sensing and transmit data
    always_ff @(posedge core_clk) begin
        if (srst) begin
            calc_volt   <= 32'h0000_0000;
            txpdo_valid <= 1'b0;
            txpdo_volt  <= 32'h0000_0000;
        end else begin
            calc_volt   <= (sense_q == lfom_pkg::SENSE_REMOTE) ?
                           meas_volt_remote : meas_volt_local;
            txpdo_valid <= txpdo_tick && (esm_q >= lfom_pkg::ESM_SAFEOP);
            if (txpdo_tick && esm_q >= lfom_pkg::ESM_SAFEOP) begin
                txpdo_volt <= calc_volt;
            end
        end
    end

    assign sense_remote = (sense_q == lfom_pkg::SENSE_REMOTE);

    // Front panel gating
    always_ff @(posedge core_clk) begin
        if (srst) begin
            panel_btn_gated <= 8'h00;
        end else begin
            panel_btn_gated <= lock_q ? (panel_btn & lfom_pkg::BTN_STOP_MASK) : panel_btn;
        end
    end

    assign panel_locked = lock_q;

    // Generator parameter selection
    lfom_fgen_sel u_fgen_sel (
        .core_clk (core_clk),
        .srst     (srst),
        .src      (src_q),
        .ftype    (ftype_q),
        .step_lo  (fparam_q[lfom_pkg::FP_STEP_LO]),
        .step_hi  (fparam_q[lfom_pkg::FP_STEP_HI]),
        .ramp_lo  (fparam_q[lfom_pkg::FP_RAMP_LO]),
        .ramp_hi  (fparam_q[lfom_pkg::FP_RAMP_HI]),
        .rise_ms  (fparam_q[lfom_pkg::FP_RISE]),
        .fall_ms  (fparam_q[lfom_pkg::FP_FALL]),
        .step_on  (fgen_step_on),
        .ramp_on  (fgen_ramp_on),
        .level_lo (fgen_level_lo),
        .level_hi (fgen_level_hi),
        .rise_out (fgen_rise_ms),
        .fall_out (fgen_fall_ms)
    );

    // Checks
    a_init_sdo_refused: assert property (
        @(posedge core_clk) disable iff (srst)
        (sdo_valid && esm_q == lfom_pkg::ESM_INIT) |=> (sdo_rsp_valid && !sdo_rsp_ok))
        else $error("service access answered ok in Init");

    a_proto_reject: assert property (
        @(posedge core_clk) disable iff (srst)
        (sdo_valid && !proto_ok) |=> (sdo_rsp_valid && !sdo_rsp_ok))
        else $error("unsupported mailbox protocol accepted");

    a_step_lo_store: assert property (
        @(posedge core_clk) disable iff (srst)
        (sdo_acc && sdo_write && sdo_instance == lfom_pkg::INST_STEP_LO_WR)
        |=> (fparam_q[lfom_pkg::FP_STEP_LO] == $past(sdo_wdata)))
        else $error("step low level not stored");

    a_step_hi_read: assert property (
        @(posedge core_clk) disable iff (srst)
        (sdo_acc && !sdo_write && sdo_instance == lfom_pkg::INST_STEP_HI_RD)
        |=> (sdo_rsp_ok && sdo_rdata == $past(fparam_q[lfom_pkg::FP_STEP_HI])))
        else $error("step high level read back wrong");

    a_txpdo_gate: assert property (
        @(posedge core_clk) disable iff (srst)
        (txpdo_tick && esm_q < lfom_pkg::ESM_SAFEOP) |=> !txpdo_valid)
        else $error("transmit data sent below Safe-Operational");

    a_rxpdo_drop: assert property (
        @(posedge core_clk) disable iff (srst)
        (rxpdo_valid && esm_q != lfom_pkg::ESM_OP && !panel_sp_valid) |=> $stable(local_sp_q))
        else $error("receive data taken below Operational");

    a_esm_skip_refused: assert property (
        @(posedge core_clk) disable iff (srst)
        (esm_req_valid && {1'b0, esm_req_state} > {1'b0, esm_q} + 3'h1)
        |=> ($stable(esm_q) && esm_refused))
        else $error("state skip not refused");

    a_lock_buttons: assert property (
        @(posedge core_clk) disable iff (srst)
        lock_q |=> (panel_btn_gated == ($past(panel_btn) & lfom_pkg::BTN_STOP_MASK)))
        else $error("button passed while locked");

    a_src_analog: assert property (
        @(posedge core_clk) disable iff (srst)
        (src_q == lfom_pkg::SRC_ANALOG) |=> (setpoint_out == $past(analog_setpoint)))
        else $error("analog set point not routed");

    a_sense_remote: assert property (
        @(posedge core_clk) disable iff (srst)
        (sense_q == lfom_pkg::SENSE_REMOTE) ##1 (sense_q == lfom_pkg::SENSE_REMOTE)
        |=> (calc_volt == $past(meas_volt_remote, 1)))
        else $error("remote sense not used for calculation");

endmodule

// File: hdl/lfom_pkg.sv
// Constants for the load fieldbus object map: instances, codes, resets.
// Assumes one clock domain and instance numbers as carried by the fieldbus.
package lfom_pkg;

    // Slave state machine
    typedef enum logic [1:0] {ESM_INIT, ESM_PREOP, ESM_SAFEOP, ESM_OP} lfom_esm_e;

    // Instance numbers
    localparam logic [15:0] INST_FTYPE_WR    = 16'h0601;
    localparam logic [15:0] INST_FTYPE_RD    = 16'h0602;
    localparam logic [15:0] INST_FPARAM_BASE = 16'h0611;
    localparam logic [15:0] FPARAM_SPAN      = 16'h000C;
    localparam logic [15:0] INST_STEP_LO_WR  = 16'h0611;
    localparam logic [15:0] INST_STEP_LO_RD  = 16'h0612;
    localparam logic [15:0] INST_STEP_HI_WR  = 16'h0613;
    localparam logic [15:0] INST_STEP_HI_RD  = 16'h0614;
    localparam logic [15:0] INST_RAMP_LO_WR  = 16'h0615;
    localparam logic [15:0] INST_RAMP_LO_RD  = 16'h0616;
    localparam logic [15:0] INST_RAMP_HI_WR  = 16'h0617;
    localparam logic [15:0] INST_RAMP_HI_RD  = 16'h0618;
    localparam logic [15:0] INST_RISE_WR     = 16'h0619;
    localparam logic [15:0] INST_RISE_RD     = 16'h061A;
    localparam logic [15:0] INST_FALL_WR     = 16'h061B;
    localparam logic [15:0] INST_FALL_RD     = 16'h061C;
    localparam logic [15:0] INST_RELOAD_WR   = 16'h0701;
    localparam logic [15:0] INST_LOCK_RD     = 16'h0702;
    localparam logic [15:0] INST_LOCK_WR     = 16'h0703;
    localparam logic [15:0] INST_SENSE_WR    = 16'h0706;
    localparam logic [15:0] INST_SENSE_RD    = 16'h0707;
    localparam logic [15:0] INST_SRC_WR      = 16'h070A;
    localparam logic [15:0] INST_SRC_RD      = 16'h070B;

    // Float parameter slots
    localparam int unsigned FP_NUM       = 6;
    localparam logic [2:0]  FP_STEP_LO   = 3'h0;
    localparam logic [2:0]  FP_STEP_HI   = 3'h1;
    localparam logic [2:0]  FP_RAMP_LO   = 3'h2;
    localparam logic [2:0]  FP_RAMP_HI   = 3'h3;
    localparam logic [2:0]  FP_RISE      = 3'h4;
    localparam logic [2:0]  FP_FALL      = 3'h5;

    // Set-point sources
    localparam logic [15:0] SRC_PANEL    = 16'h0000;
    localparam logic [15:0] SRC_FGEN     = 16'h0001;
    localparam logic [15:0] SRC_ANALOG   = 16'h0003;

    // Function types
    localparam logic [15:0] FT_SINE      = 16'h0000;
    localparam logic [15:0] FT_SQUARE    = 16'h0001;
    localparam logic [15:0] FT_STEP      = 16'h0002;
    localparam logic [15:0] FT_RAMP      = 16'h0003;

    // Sense locations and restore kinds
    localparam logic [15:0] SENSE_LOCAL  = 16'h0000;
    localparam logic [15:0] SENSE_REMOTE = 16'h0001;
    localparam logic [15:0] RESTORE_SOFT = 16'h0000;
    localparam logic [15:0] RESTORE_HARD = 16'h0001;

    // Mailbox protocol codes
    localparam logic [3:0]  PROTO_BASIC  = 4'h0;
    localparam logic [3:0]  PROTO_EOE    = 4'h2;

    // Reset values
    localparam logic [31:0] FPARAM_RST   = 32'h0000_0000;
    localparam logic [31:0] SETPOINT_RST = 32'h0000_0000;
    localparam logic [15:0] SRC_RST      = SRC_PANEL;
    localparam logic [15:0] FTYPE_RST    = FT_SINE;
    localparam logic [15:0] SENSE_RST    = SENSE_LOCAL;
    localparam logic        LOCK_RST     = 1'b0;

    // Front panel
    localparam int unsigned BTN_W        = 8;
    localparam logic [7:0]  BTN_STOP_MASK = 8'h01;

endpackage

// File: test/lfom_master.sv
// Fieldbus master model: state commands, service requests, process data.
// Assumes the slave samples on rising core_clk; requests change at falling edges.
`timescale 1ns/1ps
module lfom_master (
    // Clock
    input  wire logic           core_clk,
    // State commands
    output logic                esm_req_valid,
    output lfom_pkg::lfom_esm_e esm_req_state,
    // Service data
    output logic                sdo_valid,
    output logic                sdo_write,
    output logic [3:0]          sdo_proto,
    output logic [15:0]         sdo_instance,
    output logic [31:0]         sdo_wdata,
    // Process data
    output logic                rxpdo_valid,
    output logic [31:0]         rxpdo_setpoint,
    output logic                txpdo_tick
);
    initial begin
        {esm_req_valid, sdo_valid, sdo_write, rxpdo_valid, txpdo_tick} = 5'h00;
        esm_req_state = lfom_pkg::ESM_INIT;
        {sdo_proto, sdo_instance, sdo_wdata, rxpdo_setpoint} = 84'h0;
    end
    // Master commands state moves
    task automatic esm(input lfom_pkg::lfom_esm_e st);
        @(negedge core_clk);
        esm_req_valid = 1'b1;
        esm_req_state = st;
        @(negedge core_clk);
        esm_req_valid = 1'b0;
    endtask
    // One-cycle request between falling edges, with whatever protocol code the caller gives
    task automatic sdo(input logic wr, input logic [3:0] pr, input logic [15:0] inst,
                       input logic [31:0] d);
        @(negedge core_clk);
        {sdo_valid, sdo_write, sdo_proto, sdo_instance, sdo_wdata} = {1'b1, wr, pr, inst, d};
        @(negedge core_clk);
        sdo_valid = 1'b0;
        sdo_wdata = ~sdo_wdata;
    endtask
    // Set point inward when rx is set, otherwise a transmit tick
    task automatic pdo(input logic rx, input logic [31:0] sp);
        @(negedge core_clk);
        {rxpdo_valid, txpdo_tick, rxpdo_setpoint} = {rx, ~rx, sp};
        @(negedge core_clk);
        {rxpdo_valid, txpdo_tick, rxpdo_setpoint} = {2'h0, ~sp};
    endtask
endmodule

// File: test/tb_top.sv
// Self-checking bench for the object map against a stored-value model.
// Assumes the master model drives all fieldbus inputs.
`timescale 1ns/1ps
module tb_top;
    logic                core_clk, srst, esm_req_valid, esm_refused, sdo_valid, sdo_write;
    logic                sdo_rsp_valid, sdo_rsp_ok, rxpdo_valid, txpdo_tick, txpdo_valid;
    logic                panel_sp_valid, fgen_step_on, fgen_ramp_on, panel_locked;
    logic                sense_remote, restore_pulse, restore_hard;
    lfom_pkg::lfom_esm_e esm_req_state, esm_state;
    logic [3:0]          sdo_proto;
    logic [15:0]         sdo_instance;
    logic [7:0]          panel_btn, panel_btn_gated;
    logic [31:0]         sdo_wdata, sdo_rdata, rxpdo_setpoint, txpdo_volt, panel_setpoint;
    logic [31:0]         fgen_wave, analog_setpoint, setpoint_out, fgen_level_lo;
    logic [31:0]         fgen_level_hi, fgen_rise_ms, fgen_fall_ms, meas_volt_local;
    logic [31:0]         meas_volt_remote, calc_volt, sp;
    logic [31:0]         mdl [6];
    int                  err_total, tests_run, n_restore;

    lfom_object_map uut (.core_clk, .srst, .esm_req_valid, .esm_req_state, .esm_state,
        .esm_refused, .sdo_valid, .sdo_write, .sdo_proto, .sdo_instance, .sdo_wdata,
        .sdo_rsp_valid, .sdo_rsp_ok, .sdo_rdata, .rxpdo_valid, .rxpdo_setpoint, .txpdo_tick,
        .txpdo_valid, .txpdo_volt, .panel_sp_valid, .panel_setpoint, .fgen_wave,
        .analog_setpoint, .setpoint_out, .fgen_step_on, .fgen_ramp_on, .fgen_level_lo,
        .fgen_level_hi, .fgen_rise_ms, .fgen_fall_ms, .panel_btn, .panel_btn_gated,
        .panel_locked, .meas_volt_local, .meas_volt_remote, .calc_volt, .sense_remote,
        .restore_pulse, .restore_hard);
    lfom_master m (.core_clk, .esm_req_valid, .esm_req_state, .sdo_valid, .sdo_write,
        .sdo_proto, .sdo_instance, .sdo_wdata, .rxpdo_valid, .rxpdo_setpoint, .txpdo_tick);

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Restore pulses: soft counts 1, hard counts 17
    always @(posedge core_clk) begin
        if (restore_pulse === 1'b1) n_restore += (restore_hard === 1'b1) ? 17 : 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic svc(input logic wr, input logic [3:0] pr, input logic [15:0] inst,
                       input logic [31:0] d, input logic ok, input logic [31:0] rd);
        m.sdo(wr, pr, inst, d);
        chk({sdo_rsp_valid, sdo_rsp_ok}, {1'b1, ok});
        chk(sdo_rdata, rd);
    endtask
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #(5000 * 100);
        err_total++;
        conclude();
    end
    initial begin
        void'($urandom(92244));
        {err_total, tests_run, n_restore} = '0;
        srst = 1'b1;
        {panel_sp_valid, panel_btn} = 9'h0FF;
        {panel_setpoint, fgen_wave, analog_setpoint} = {$urandom, $urandom, $urandom};
        {meas_volt_local, meas_volt_remote, sp} = {$urandom, $urandom, $urandom};
        repeat (16) @(negedge core_clk);
        srst = 1'b0;
        chk(32'(esm_state), 32'h0);
        @(negedge core_clk);
        chk(32'(panel_btn_gated), 32'hFF);
        svc(1'b0, 4'h0, lfom_pkg::INST_STEP_LO_RD, 32'h0, 1'b0, 32'h0);
        m.esm(lfom_pkg::ESM_PREOP);
        chk(32'(esm_state), 32'h1);
        m.esm(lfom_pkg::ESM_OP);
        chk({esm_refused, esm_state}, 32'h5);
        for (int i = 0; i < 6; i++) begin
            mdl[i] = $urandom;
            svc(1'b1, 4'h0, lfom_pkg::INST_STEP_LO_WR + 16'(2 * i), mdl[i], 1'b1, 32'h0);
        end
        for (int i = 0; i < 6; i++)
            svc(1'b0, 4'h2, lfom_pkg::INST_STEP_LO_RD + 16'(2 * i), 32'h0, 1'b1, mdl[i]);
        svc(1'b0, 4'h0, lfom_pkg::INST_STEP_LO_WR, 32'h0, 1'b0, 32'h0);
        svc(1'b0, 4'h3, lfom_pkg::INST_STEP_LO_RD, 32'h0, 1'b0, 32'h0);
        svc(1'b1, 4'h0, lfom_pkg::INST_SRC_WR, 32'h2, 1'b0, 32'h0);
        svc(1'b1, 4'h0, lfom_pkg::INST_SRC_WR, 32'h1, 1'b1, 32'h0);
        for (int t = 0; t < 4; t++) begin
            svc(1'b1, 4'h0, lfom_pkg::INST_FTYPE_WR, 32'(t), 1'b1, 32'h0);
            repeat (3) @(negedge core_clk);
            chk({fgen_step_on, fgen_ramp_on}, {t == 2, t == 3});
            chk(fgen_level_lo, t == 2 ? mdl[0] : t == 3 ? mdl[2] : 32'h0);
            chk(fgen_fall_ms, t == 3 ? mdl[5] : 32'h0);
            chk(fgen_level_hi, t == 2 ? mdl[1] : t == 3 ? mdl[3] : 32'h0);
            chk(fgen_rise_ms, t == 3 ? mdl[4] : 32'h0);
        end
        svc(1'b1, 4'h0, lfom_pkg::INST_LOCK_WR, 32'h1, 1'b1, 32'h0);
        svc(1'b0, 4'h0, lfom_pkg::INST_LOCK_RD, 32'h0, 1'b1, 32'h1);
        chk(32'(panel_locked), 32'h1);
        repeat (2) @(negedge core_clk);
        chk(32'(panel_btn_gated), 32'h01);
        svc(1'b1, 4'h0, lfom_pkg::INST_SENSE_WR, 32'h1, 1'b1, 32'h0);
        repeat (3) @(negedge core_clk);
        chk(calc_volt, meas_volt_remote);
        chk(32'(sense_remote), 32'h1);
        svc(1'b1, 4'h0, lfom_pkg::INST_SRC_WR, 32'h0, 1'b1, 32'h0);
        m.pdo(1'b1, ~sp);
        repeat (3) @(negedge core_clk);
        chk(setpoint_out, 32'h0);
        m.esm(lfom_pkg::ESM_SAFEOP);
        m.pdo(1'b0, 32'h0);
        chk({txpdo_valid, txpdo_volt}, {1'b1, meas_volt_remote});
        m.esm(lfom_pkg::ESM_OP);
        m.pdo(1'b1, sp);
        repeat (2) @(negedge core_clk);
        chk(setpoint_out, sp);
        svc(1'b1, 4'h0, lfom_pkg::INST_SRC_WR, 32'h3, 1'b1, 32'h0);
        repeat (2) @(negedge core_clk);
        chk(setpoint_out, analog_setpoint);
        svc(1'b0, 4'h0, lfom_pkg::INST_SRC_RD, 32'h0, 1'b1, 32'h3);
        svc(1'b1, 4'h0, lfom_pkg::INST_RELOAD_WR, 32'h0, 1'b1, 32'h0);
        svc(1'b0, 4'h0, lfom_pkg::INST_LOCK_RD, 32'h0, 1'b1, 32'h0);
        svc(1'b0, 4'h0, lfom_pkg::INST_SRC_RD, 32'h0, 1'b1, 32'h0);
        svc(1'b0, 4'h0, lfom_pkg::INST_STEP_LO_RD, 32'h0, 1'b1, mdl[0]);
        svc(1'b1, 4'h0, lfom_pkg::INST_RELOAD_WR, 32'h1, 1'b1, 32'h0);
        svc(1'b0, 4'h0, lfom_pkg::INST_STEP_LO_RD, 32'h0, 1'b1, 32'h0);
        chk(n_restore, 18);
        conclude();
    end
endmodule
